/* inc/dsp_pkg.sv */
// Purpose: Shared constants and types for the DRAM strobe pin interface.
// Assumes: 10 MHz bus clock, one access at a time.
// Notes:   Address split and state codes live here.
package dsp_pkg;
	localparam int MUX_W      = 12;
	localparam int ROW_LSB    = 14;
	localparam int COL_LSB    = 2;
	localparam int BANK_LSB   = 26;
	localparam int BANK_W     = 2;
	localparam int LANES      = 4;
	localparam int BANKS      = 4;
	localparam logic [3:0] STROBES_IDLE = 4'hF;
	localparam logic [3:0] LANES_NONE   = 4'h0;

	typedef enum logic [2:0]
	{
		ST_IDLE = 3'b000,
		ST_ROW  = 3'b001,
		ST_COL  = 3'b010,
		ST_WAIT = 3'b011,
		ST_DONE = 3'b100
	} dsp_state_e;
endpackage

/* inc/dsp_lane_if.sv */
// Purpose: Carries lane and bank selects from the sequencer to the pin stage.
// Assumes: One clock domain.
// Notes:   All fields are active high.
`timescale 1ns/1ns
interface dsp_lane_if;
	logic [3:0] bank_sel;
	logic [3:0] lane_sel;
	logic       ras_act;
	logic       cas_act;
	logic       we_act;
	logic       oe_act;

	modport seq
	(
		output bank_sel, lane_sel, ras_act, cas_act, we_act, oe_act
	);
	modport pins
	(
		input  bank_sel, lane_sel, ras_act, cas_act, we_act, oe_act
	);
endinterface

/* rtl/dsp_sync.sv */
// Purpose: Two flip-flop synchroniser for pin inputs.
// Assumes: Reset level given by parameter.
// Notes:   First stage feeds only the second.
`timescale 1ns/1ns
module dsp_sync
#(
	parameter logic RST_VAL = 1'b1
)
(
	input  wire logic clk_in,
	input  wire logic rst_n_in,
	input  wire logic d_in,
	output logic      q_out
);
	logic meta_r;

	always_ff @(posedge clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			meta_r <= RST_VAL;
			q_out  <= RST_VAL;
		end
		else
		begin
			meta_r <= d_in;
			q_out  <= meta_r;
		end
	end
endmodule

/* rtl/dsp_pins.sv */
// Purpose: Registers strobe pins from sequencer selects.
// Assumes: Mode straps are stable during an access.
// Notes:   Every strobe is registered, so pins are glitch free.
`timescale 1ns/1ns
module dsp_pins
	import dsp_pkg::*;
(
	input  wire logic   clk_in,
	input  wire logic   rst_n_in,
	input  wire logic   two_we_in,
	input  wire logic   bus16_in,
	dsp_lane_if.pins    sel,
	output logic [3:0]  ras_n_out,
	output logic [3:0]  cas_n_out,
	output logic [3:0]  we_n_out,
	output logic        oe_n_out
);
	wire [3:0] cas_lanes;
	wire [3:0] we_lanes;
	wire [3:0] ras_nxt;
	wire [3:0] cas_nxt;
	wire [3:0] we_nxt;
	wire [3:0] lane_eff;

	// In 16-bit mode lanes 0 and 1 are held idle, a safe undefined level.
	assign lane_eff  = bus16_in ? {sel.lane_sel[3:2], 2'b00} : sel.lane_sel;
	assign cas_lanes = two_we_in ? 4'hF : lane_eff;
	assign we_lanes  = two_we_in ? lane_eff : 4'hF;
	assign ras_nxt   = sel.ras_act ? ~sel.bank_sel : STROBES_IDLE;
	assign cas_nxt   = sel.cas_act ? ~cas_lanes : STROBES_IDLE;
	assign we_nxt    = sel.we_act ? ~we_lanes : STROBES_IDLE;

	// Reset drives every strobe inactive high.
	always_ff @(posedge clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			ras_n_out <= STROBES_IDLE;
			cas_n_out <= STROBES_IDLE;
			we_n_out  <= STROBES_IDLE;
			oe_n_out  <= 1'b1;
		end
		else
		begin
			ras_n_out <= ras_nxt;
			cas_n_out <= cas_nxt;
			we_n_out  <= we_nxt;
			oe_n_out  <= ~sel.oe_act;
		end
	end
endmodule

/* rtl/dsp_top.sv */
// Purpose: DRAM strobe and multiplexed address pin controller.
// Assumes: 10 MHz bus clock; ready ends the access.
// Notes:   Access request comes from the bus unit on the same clock.
//
// What this block does
// - Four active-low row strobes, only the accessed bank's asserted.
// - 32-bit two-CAS: column strobe 0 bits 31..24 down to 3 bits 7..0.
// - 16-bit two-CAS: strobe 2 even byte, strobe 3 odd byte.
// - 16-bit mode: strobes 0 and 1 undefined; board must ignore them.
// - Two-WE: all four column strobes identical.
// - Two-WE: write enables 0..3 each control one byte lane.
// - Two-CAS: all four write enables identical.
// - EDO: output enable steers memory data output high impedance.
// - Row then column address multiplexed onto address pins 13..2.
// - Bus granted: drive address only if enabled, strobe to ready.
// - During reset row, column strobes and output enable driven high.
// - Bus granted: strobes and output enable keep valid levels.
// - During reset address pins driven, value zero.
// - DRAM burst: burst request asserted, answered internally.
`timescale 1ns/1ns
module dsp_top
	import dsp_pkg::*;
(
	// Clock and reset
	input  wire logic        MCLK_IN,
	input  wire logic        RST_N_IN,
	// Configuration
	input  wire logic        DRAM_ENABLE_IN,
	input  wire logic        BUS16_IN,
	input  wire logic        TWO_WE_IN,
	input  wire logic        EDO_IN,
	input  wire logic        DRAM_BURST_EN_IN,
	input  wire logic        BUS_GRANTED_IN,
	// Bus unit access (same clock)
	input  wire logic        ADDR_STROBE_N_IN,
	input  wire logic [27:2] ADDR_IN,
	input  wire logic [3:0]  BYTE_EN_IN,
	input  wire logic        WRITE_IN,
	// External bus pins
	input  wire logic        EXT_ADDR_STROBE_N_IN,
	input  wire logic        READY_N_IN,
	// DRAM pins
	output logic [3:0]       ROW_STROBE_N_OUT,
	output logic [3:0]       COL_STROBE_N_OUT,
	output logic [3:0]       MEM_WRITE_EN_N_OUT,
	output logic             MEM_OUTPUT_EN_N_OUT,
	output logic [13:2]      MUX_ADDR_OUT,
	output logic             MUX_ADDR_OE_OUT,
	output logic             BURST_REQUEST_N_OUT,
	output logic             BURST_ACK_INT_OUT,
	output logic             BUSY_OUT
);
	dsp_state_e      state_r;
	dsp_state_e      state_nxt;
	logic [27:2]     addr_r;
	logic [3:0]      be_r;
	logic            wr_r;
	logic [13:2]     mux_r;
	logic            oe_r;
	logic            burst_r;
	logic            ext_as_n_s;
	logic            ready_n_s;
	logic            ext_as_d_r;
	logic            grant_drive_r;

	dsp_lane_if      lane ();

	////////////////////////////////////////////////////////////////////////
	dsp_sync #(.RST_VAL(1'b1)) u_sync_as
	(
		.clk_in   (MCLK_IN),
		.rst_n_in (RST_N_IN),
		.d_in     (EXT_ADDR_STROBE_N_IN),
		.q_out    (ext_as_n_s)
	);

	dsp_sync #(.RST_VAL(1'b1)) u_sync_rdy
	(
		.clk_in   (MCLK_IN),
		.rst_n_in (RST_N_IN),
		.d_in     (READY_N_IN),
		.q_out    (ready_n_s)
	);

	////////////////////////////////////////////////////////////////////////
	wire        start      = !ADDR_STROBE_N_IN && !BUS_GRANTED_IN
		&& DRAM_ENABLE_IN;
	wire        ready      = !ready_n_s;
	wire [1:0]  bank_idx   = addr_r[BANK_LSB +: BANK_W];
	wire [11:0] col_addr   = addr_r[COL_LSB +: MUX_W];
	wire        in_access  = (state_r != ST_IDLE) && (state_r != ST_DONE);
	wire        ext_as_fall = ext_as_d_r && !ext_as_n_s;

	// Lanes follow the transfer's byte enables only.
	assign lane.bank_sel = 4'h1 << bank_idx;
	assign lane.lane_sel = be_r;
	assign lane.ras_act  = in_access;
	assign lane.cas_act  = (state_r == ST_COL) || (state_r == ST_WAIT);
	// Write enable leads column strobe for early write.
	assign lane.we_act   = wr_r && in_access && (state_r != ST_ROW) ? 1'b1
		: (wr_r && state_r == ST_ROW);
	assign lane.oe_act   = oe_r;

	always_comb
	begin
		state_nxt = state_r;
		case (state_r)
			ST_IDLE: state_nxt = start ? ST_ROW : ST_IDLE;
			ST_ROW:  state_nxt = ST_COL;
			ST_COL:  state_nxt = ST_WAIT;
			ST_WAIT: state_nxt = ready ? ST_DONE : ST_WAIT;
			ST_DONE: state_nxt = ST_IDLE;
			default: state_nxt = ST_IDLE;
		endcase
	end

	////////////////////////////////////////////////////////////////////////
	always_ff @(posedge MCLK_IN or negedge RST_N_IN)
	begin
		if (!RST_N_IN)
		begin
			state_r <= ST_IDLE;
			addr_r  <= '0;
			be_r    <= LANES_NONE;
			wr_r    <= 1'b0;
		end
		else
		begin
			state_r <= state_nxt;
			if (state_r == ST_IDLE && start)
			begin
				addr_r <= ADDR_IN;
				be_r   <= BYTE_EN_IN;
				wr_r   <= WRITE_IN;
			end
		end
	end

	// Address pins drive in reset; value is the zero that reset loads.
	always_ff @(posedge MCLK_IN or negedge RST_N_IN)
	begin
		if (!RST_N_IN)
		begin
			mux_r <= '0;
			oe_r  <= 1'b0;
		end
		else
		begin
			mux_r <= (state_nxt == ST_ROW) ? ADDR_IN[ROW_LSB +: MUX_W]
				: (state_nxt == ST_ROW || state_r == ST_IDLE) ? mux_r
				: (state_r == ST_ROW) ? col_addr : mux_r;
			oe_r  <= EDO_IN && !wr_r && (state_nxt == ST_COL
				|| state_nxt == ST_WAIT);
		end
	end

	// While granted, drive from the third clock edge after the strobe pin falls until ready.
	always_ff @(posedge MCLK_IN or negedge RST_N_IN)
	begin
		if (!RST_N_IN)
		begin
			ext_as_d_r    <= 1'b1;
			grant_drive_r <= 1'b0;
			burst_r       <= 1'b1;
		end
		else
		begin
			ext_as_d_r <= ext_as_n_s;
			if (!BUS_GRANTED_IN || !DRAM_ENABLE_IN || ready)
				grant_drive_r <= 1'b0;
			else if (ext_as_fall)
				grant_drive_r <= 1'b1;
			burst_r <= !(DRAM_BURST_EN_IN && (start || in_access));
		end
	end

	////////////////////////////////////////////////////////////////////////
	dsp_pins u_pins
	(
		.clk_in    (MCLK_IN),
		.rst_n_in  (RST_N_IN),
		.two_we_in (TWO_WE_IN),
		.bus16_in  (BUS16_IN),
		.sel       (lane),
		.ras_n_out (ROW_STROBE_N_OUT),
		.cas_n_out (COL_STROBE_N_OUT),
		.we_n_out  (MEM_WRITE_EN_N_OUT),
		.oe_n_out  (MEM_OUTPUT_EN_N_OUT)
	);

	// Reset holds the pins as outputs; granted bus drives only as allowed.
	assign MUX_ADDR_OUT        = mux_r;
	assign MUX_ADDR_OE_OUT     = !RST_N_IN || (BUS_GRANTED_IN ? grant_drive_r
		: DRAM_ENABLE_IN);
	assign BURST_REQUEST_N_OUT = burst_r;
	assign BURST_ACK_INT_OUT   = DRAM_BURST_EN_IN && (state_r == ST_DONE);
	assign BUSY_OUT            = in_access;
endmodule

/* testbench/dsp_checker.sv */
// Purpose: Assertions on the DRAM strobe pins.
// Assumes: Mode inputs change only while idle.
// Notes:   Bound to the top module.
`timescale 1ns/1ns
module dsp_checker
(
	// Watched ports
	input wire logic        MCLK_IN,
	input wire logic        RST_N_IN,
	input wire logic        DRAM_ENABLE_IN,
	input wire logic        BUS16_IN,
	input wire logic        TWO_WE_IN,
	input wire logic        EDO_IN,
	input wire logic        BUS_GRANTED_IN,
	input wire logic        ADDR_STROBE_N_IN,
	input wire logic        BUSY_OUT,
	input wire logic [3:0]  ROW_STROBE_N_OUT,
	input wire logic [3:0]  COL_STROBE_N_OUT,
	input wire logic [3:0]  MEM_WRITE_EN_N_OUT,
	input wire logic        MEM_OUTPUT_EN_N_OUT,
	input wire logic        MUX_ADDR_OE_OUT
);
	default clocking @(posedge MCLK_IN); endclocking
	default disable iff (!RST_N_IN);
	sequence s_take;
		!ADDR_STROBE_N_IN && DRAM_ENABLE_IN && !BUS_GRANTED_IN && !BUSY_OUT;
	endsequence
	sequence s_row_on;
		$past(ROW_STROBE_N_OUT) == 4'hF && ROW_STROBE_N_OUT != 4'hF;
	endsequence
	a_take_row: assert property (s_take |-> ##1 ROW_STROBE_N_OUT == 4'hF
		##1 ROW_STROBE_N_OUT != 4'hF) else $error("row strobe late");
	a_col_follows: assert property (s_row_on |-> COL_STROBE_N_OUT == 4'hF
		##1 COL_STROBE_N_OUT != 4'hF) else $error("column strobe late");
	a_one_bank: assert property ($countones(~ROW_STROBE_N_OUT) <= 1)
		else $error("two banks strobed");
	a_two_we_cas: assert property (TWO_WE_IN |-> COL_STROBE_N_OUT == 4'h0
		|| COL_STROBE_N_OUT == 4'hF) else $error("column strobes differ");
	a_two_cas_we: assert property (!TWO_WE_IN |-> MEM_WRITE_EN_N_OUT == 4'h0
		|| MEM_WRITE_EN_N_OUT == 4'hF) else $error("write enables differ");
	a_half_lanes: assert property (BUS16_IN && !TWO_WE_IN
		|-> COL_STROBE_N_OUT[1:0] == 2'b11) else $error("low lanes active");
	a_oe_edo_only: assert property (!MEM_OUTPUT_EN_N_OUT |-> EDO_IN)
		else $error("output enable in fast page");
	a_granted_hiz: assert property (BUS_GRANTED_IN && !DRAM_ENABLE_IN
		|-> !MUX_ADDR_OE_OUT) else $error("address driven");
	a_reset_idle: assert property ($rose(RST_N_IN) |-> ROW_STROBE_N_OUT
		== 4'hF && COL_STROBE_N_OUT == 4'hF && MEM_OUTPUT_EN_N_OUT)
		else $error("strobes low at reset");
endmodule
////////////////////////////////////////////////////////////////////////////////
bind dsp_top dsp_checker i_chk (.MCLK_IN, .RST_N_IN, .DRAM_ENABLE_IN,
	.BUS16_IN, .TWO_WE_IN, .EDO_IN, .BUS_GRANTED_IN, .ADDR_STROBE_N_IN,
	.BUSY_OUT, .ROW_STROBE_N_OUT, .COL_STROBE_N_OUT, .MEM_WRITE_EN_N_OUT,
	.MEM_OUTPUT_EN_N_OUT, .MUX_ADDR_OE_OUT);

/* testbench/dsp_dram_model.sv */
// Purpose: DRAM bank model answering with ready after a delay.
// Assumes: Ready line has a pull-up.
// Notes:   Flags a write enable that falls after its column strobe.
`timescale 1ns/1ns
module dsp_dram_model
(
	input  wire logic       clk_in,
	input  wire logic [3:0] row_n_in,
	input  wire logic [3:0] col_n_in,
	input  wire logic [3:0] we_n_in,
	input  wire logic [3:0] delay_in,
	output logic            ready_n_out,
	output logic            late_write_out
);
	logic [3:0] cnt_r;
	logic [3:0] we_r;
	logic [3:0] col_r;
	initial
	begin
		{ready_n_out, late_write_out, cnt_r, we_r, col_r} = 14'h20FF;
	end
	always @(posedge clk_in)
	begin
		// Any asserted strobe counts, so low lanes never matter.
		if (row_n_in == 4'hF)
		begin
			cnt_r <= 4'h0;
			ready_n_out <= 1'b1;
		end
		else if (col_n_in != 4'hF)
		begin
			cnt_r <= cnt_r + 4'h1;
			ready_n_out <= (cnt_r < delay_in);
		end
		if (|(~we_n_in & we_r & ~col_r))
			late_write_out <= 1'b1;
		we_r <= we_n_in;
		col_r <= col_n_in;
	end
endmodule

/* testbench/dsp_top_tb.sv */
// Purpose: Self-checking bench for the DRAM strobe pins.
// Assumes: Inputs change at the falling edge.
// Notes:   All eight mode combinations run, then grant and reset tests.
`timescale 1ns/1ns
`define CHK(n,e,a) begin checks_done++; if ((a) !== (e)) begin err_count++; \
$display("mismatch %s exp %h got %h", n, e, a); end end
module dsp_top_tb;
	logic clk, rst_n, en, b16, twe, edo, bst, gnt, as_n, wr, eas_n, rdy_n;
	logic late, oe, moe, brq, back, busy, seen;
	logic [27:2] adr;
	logic [3:0] be, row, col, we, dly;
	logic [13:2] mux;
	int err_count, checks_done, cyc;
	dsp_top i_dut (.MCLK_IN(clk), .RST_N_IN(rst_n), .DRAM_ENABLE_IN(en),
		.BUS16_IN(b16), .TWO_WE_IN(twe), .EDO_IN(edo), .DRAM_BURST_EN_IN(bst),
		.BUS_GRANTED_IN(gnt), .ADDR_STROBE_N_IN(as_n), .ADDR_IN(adr),
		.BYTE_EN_IN(be), .WRITE_IN(wr), .EXT_ADDR_STROBE_N_IN(eas_n),
		.READY_N_IN(rdy_n), .ROW_STROBE_N_OUT(row), .COL_STROBE_N_OUT(col),
		.MEM_WRITE_EN_N_OUT(we), .MEM_OUTPUT_EN_N_OUT(oe), .MUX_ADDR_OUT(mux),
		.MUX_ADDR_OE_OUT(moe), .BURST_REQUEST_N_OUT(brq),
		.BURST_ACK_INT_OUT(back), .BUSY_OUT(busy));
	dsp_dram_model i_mem (.clk_in(clk), .row_n_in(row), .col_n_in(col),
		.we_n_in(we), .delay_in(dly), .ready_n_out(rdy_n),
		.late_write_out(late));
	task summarize;
		$display("checks %0d mismatches %0d", checks_done, err_count);
		if (err_count == 0 && checks_done > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task automatic acc;
		int n;
		as_n = 1'b0;
		@(negedge clk);
		as_n = 1'b1;
		`CHK("mux_row", adr[25:14], mux)
		repeat (2) @(negedge clk);
		`CHK("row", ~(4'h1 << adr[27:26]), row)
		`CHK("col", twe ? 4'h0 : b16 ? {~be[3:2], 2'b11} : ~be, col)
		`CHK("we", !wr ? 4'hF : twe ? ~be : 4'h0, we)
		`CHK("oe", !(edo && !wr), oe)
		`CHK("mux_col", adr[13:2], mux)
		`CHK("addr_oe", 1'b1, moe)
		n = 0;
		seen = 1'b0;
		while (busy === 1'b1 && n < 40)
		begin
			seen = seen | (brq === 1'b0);
			@(negedge clk);
			n++;
		end
		`CHK("busy", 1'b0, busy)
		`CHK("burst_ack", bst, back)
		`CHK("burst", bst, seen)
		`CHK("late", 1'b0, late)
		@(negedge clk);
	endtask
	initial
	begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 2000)
		begin
			err_count++;
			summarize();
		end
	end
	initial
	begin
		{en, b16, twe, edo, bst, gnt, wr, rst_n} = 8'h00;
		{as_n, eas_n, adr, be, dly} = 36'h0_0000_0000;
		as_n = 1'b1;
		eas_n = 1'b1;
		void'($urandom(32'h29f9_80a4));
		repeat (5) @(negedge clk);
		`CHK("rst_col", 4'hF, col)
		`CHK("rst_addr_oe", 1'b1, moe)
		rst_n = 1'b1;
		en = 1'b1;
		for (int m = 0; m < 8; m++)
		begin
			{b16, twe, edo} = m[2:0];
			for (int k = 0; k < 4; k++)
			begin
				adr = 26'($urandom);
				adr[27:26] = k[1:0];
				be = b16 ? {2'($urandom_range(3, 1)), 2'b00} : 4'($urandom_range(15, 1));
				{wr, bst} = 2'($urandom);
				dly = 4'($urandom_range(6, 0));
				acc();
			end
			$display("test mode %0d done", m);
		end
		{gnt, en, as_n} = 3'b100;
		repeat (4) @(negedge clk);
		`CHK("gnt_row", 4'hF, row)
		`CHK("gnt_oe", 1'b0, moe)
		{en, eas_n} = 2'b10;
		repeat (4) @(negedge clk);
		`CHK("gnt_drive", 1'b1, moe)
		`CHK("gnt_col", 4'hF, col)
		{gnt, eas_n} = 2'b01;
		$display("test grant done");
		@(negedge clk);
		as_n = 1'b1;
		repeat (2) @(negedge clk);
		`CHK("pre_rst_row", ~(4'h1 << adr[27:26]), row)
		rst_n = 1'b0;
		@(negedge clk);
		`CHK("rst2_row", 4'hF, row)
		`CHK("rst2_col", 4'hF, col)
		`CHK("rst2_oe", 1'b1, oe)
		`CHK("rst2_addr_oe", 1'b1, moe)
		rst_n = 1'b1;
		acc();
		$display("test reset done");
		summarize();
	end
endmodule
